// >>> ibt_regs.svh
/*
  Offsets, field positions, reset values and timing counts of the I2C
  bit-timing and bus-timeout block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef IBT_REGS_SVH
`define IBT_REGS_SVH

// Register byte offsets
`define IBT_OFF_BIT_TIMING   12'h010
`define IBT_OFF_TIMEOUT_CFG  12'h014
`define IBT_OFF_CONTROL      12'h018
`define IBT_OFF_IRQ_STATUS   12'h01C
`define IBT_OFF_IRQ_ENABLE   12'h020
`define IBT_OFF_IRQ_CLEAR    12'h024

// Reset values
`define IBT_RST_BIT_TIMING   32'h00000000
`define IBT_RST_TIMEOUT_CFG  32'h00000000

// Bit timing fields
`define IBT_LOW_LSB      0
`define IBT_LOW_MSB      7
`define IBT_HIGH_LSB     8
`define IBT_HIGH_MSB     15
`define IBT_HOLD_LSB     16
`define IBT_HOLD_MSB     19
`define IBT_SETUP_LSB    20
`define IBT_SETUP_MSB    23
`define IBT_PSC_LSB      28
`define IBT_PSC_MSB      31
`define IBT_TIMING_MASK  32'hF0FFFFFF

// Timeout fields
`define IBT_TOA_LSB      0
`define IBT_TOA_MSB      11
`define IBT_IDLE_SEL_BIT 12
`define IBT_CLKTO_EN_BIT 15
`define IBT_TOB_LSB      16
`define IBT_TOB_MSB      27
`define IBT_EXTO_EN_BIT  31
`define IBT_TIMEOUT_MASK 32'h8FFF9FFF

// Control register bits
`define IBT_CTL_EN_BIT   0
`define IBT_CTL_MST_BIT  1

// Interrupt bits
`define IBT_IRQ_LOWTO    0
`define IBT_IRQ_IDLETO   1
`define IBT_IRQ_EXTTO    2
`define IBT_IRQ_W        3

// Timeout scale shifts: each limit step is 1 << N kernel clock periods
`define IBT_LONG_SCALE   11
`define IBT_IDLE_SCALE   2

`endif

// >>> ibt_pkg.sv
/*
  Types shared by the bit-timing and bus-timeout block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ibt_pkg;
  typedef enum logic [2:0] {
    IBT_IDLE,
    IBT_LOW_HOLD,
    IBT_LOW_SETUP,
    IBT_LOW_REST,
    IBT_HIGH
  } ibt_phase_e;
endpackage

// >>> ibt_timeout.sv
/*
  Interval counter that flags when a monitored condition lasts
  (limit + 1) << scale kernel clock periods.
  Assumes limit is stable while enabled.
*/
`timescale 1ns/1ps
module ibt_timeout #(
  parameter int LIMIT_W = 12,
  parameter int SCALE   = 11
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               enable,
  input  wire logic               active,
  input  wire logic               restart,
  input  wire logic [LIMIT_W-1:0] limit,
  output logic                    expired
);
  localparam int CW = LIMIT_W + SCALE + 1;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          exp_q;
  logic          exp_d;
  logic [CW-1:0] thresh;

  // Threshold and counting
  always_comb begin
    thresh = CW'({1'b0, limit} + 13'h0001) << SCALE;
    cnt_d  = cnt_q;
    exp_d  = 1'b0;
    if (!enable || restart || !active) begin
      cnt_d = '0;
    end else if (cnt_q != thresh) begin
      cnt_d = cnt_q + CW'(1);
      exp_d = (cnt_q + CW'(1)) == thresh;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule

// >>> ibt_core.sv
/*
  APB register slave, prescaled SCL/SDA bit timing generator and three
  bus-timeout detectors for an I2C controller.
  Assumes synchronous SCL/SDA inputs and a shifter supplying bits.
*/
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "ibt_regs.svh"
module ibt_core (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        xfer_active,
  input  wire logic        tx_bit,
  input  wire logic        tx_mode,
  output logic             scl_oe_n,
  output logic             sda_oe_n,
  output logic             bit_done,
  output logic             timeout_err,
  output logic             irq
);
  logic [31:0] timing_q, timing_d;
  logic [31:0] tocfg_q, tocfg_d;
  logic [1:0]  ctl_q, ctl_d;
  logic [2:0]  sts_q, sts_d;
  logic [2:0]  ien_q, ien_d;
  logic [31:0] rdata_q, rdata_d;
  logic        rdy_q, rdy_d;
  logic        err_q, err_d;
  logic        irq_q, irq_d;
  logic        toerr_q, toerr_d;
  logic        wr_acc, rd_acc;
  logic        periph_en;

  // Decoded APB phases
  assign wr_acc    = psel && penable && pwrite && !rdy_q;
  assign rd_acc    = psel && penable && !pwrite && !rdy_q;
  assign periph_en = ctl_q[`IBT_CTL_EN_BIT];

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `IBT_OFF_BIT_TIMING) || (a == `IBT_OFF_TIMEOUT_CFG) ||
             (a == `IBT_OFF_CONTROL) || (a == `IBT_OFF_IRQ_STATUS) ||
             (a == `IBT_OFF_IRQ_ENABLE) || (a == `IBT_OFF_IRQ_CLEAR);
  endfunction

  // Timeout detector hookup
  logic [2:0] ev;
  logic       lowto, idleto, extto;
  logic       idle_sel, clkto_en, exto_en;
  logic       xfer_q;
  assign idle_sel = tocfg_q[`IBT_IDLE_SEL_BIT];
  assign clkto_en = tocfg_q[`IBT_CLKTO_EN_BIT];
  assign exto_en  = tocfg_q[`IBT_EXTO_EN_BIT];

  // Register file next state
  always_comb begin
    timing_d = timing_q;
    tocfg_d  = tocfg_q;
    ctl_d    = ctl_q;
    ien_d    = ien_q;
    sts_d    = sts_q;
    rdata_d  = 32'h00000000;
    rdy_d    = 1'b0;
    err_d    = 1'b0;
    if (psel && penable && !rdy_q) begin
      rdy_d = 1'b1;
      err_d = !mapped(paddr);
    end
    if (wr_acc) begin
      unique case (paddr)
        `IBT_OFF_BIT_TIMING: begin
          if (!periph_en) begin
            timing_d = pwdata & `IBT_TIMING_MASK;
          end
        end
        `IBT_OFF_TIMEOUT_CFG: tocfg_d = pwdata & `IBT_TIMEOUT_MASK;
        `IBT_OFF_CONTROL:     ctl_d   = pwdata[1:0];
        `IBT_OFF_IRQ_ENABLE:  ien_d   = pwdata[2:0];
        `IBT_OFF_IRQ_CLEAR:   sts_d   = sts_q & ~pwdata[2:0];
        default: ;
      endcase
    end
    if (rd_acc) begin
      unique case (paddr)
        `IBT_OFF_BIT_TIMING:  rdata_d = timing_q;
        `IBT_OFF_TIMEOUT_CFG: rdata_d = tocfg_q;
        `IBT_OFF_CONTROL:     rdata_d = {30'h00000000, ctl_q};
        `IBT_OFF_IRQ_STATUS:  rdata_d = {29'h00000000, sts_q};
        `IBT_OFF_IRQ_ENABLE:  rdata_d = {29'h00000000, ien_q};
        default:              rdata_d = 32'h00000000;
      endcase
    end
    sts_d   = sts_d | ev; // Set wins over clear
    irq_d   = |(sts_d & ien_d);
    toerr_d = |ev;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timing_q <= `IBT_RST_BIT_TIMING;
      tocfg_q  <= `IBT_RST_TIMEOUT_CFG;
      ctl_q    <= 2'h0;
      ien_q    <= 3'h0;
      sts_q    <= 3'h0;
      rdata_q  <= 32'h00000000;
      rdy_q    <= 1'b0;
      err_q    <= 1'b0;
      irq_q    <= 1'b0;
      toerr_q  <= 1'b0;
    end else begin
      timing_q <= timing_d;
      tocfg_q  <= tocfg_d;
      ctl_q    <= ctl_d;
      ien_q    <= ien_d;
      sts_q    <= sts_d;
      rdata_q  <= rdata_d;
      rdy_q    <= rdy_d;
      err_q    <= err_d;
      irq_q    <= irq_d;
      toerr_q  <= toerr_d;
    end
  end

  assign prdata      = rdata_q;
  assign pready      = rdy_q;
  assign pslverr     = err_q;
  assign irq         = irq_q;
  assign timeout_err = toerr_q;

  // Prescaler: one-cycle tick every (divider + 1) clocks
  logic [3:0] psc_q, psc_d;
  logic       tick_q, tick_d;
  always_comb begin
    psc_d  = psc_q;
    tick_d = 1'b0;
    if (!periph_en) begin
      psc_d = 4'h0;
    end else if (psc_q == timing_q[`IBT_PSC_MSB:`IBT_PSC_LSB]) begin
      psc_d  = 4'h0;
      tick_d = 1'b1;
    end else begin
      psc_d = psc_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      psc_q  <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      psc_q  <= psc_d;
      tick_q <= tick_d;
    end
  end

  // Bit phase sequencer: low (hold, setup) then high
  ibt_pkg::ibt_phase_e ph_q, ph_d;
  logic [7:0] units_q, units_d;
  logic       scl_n_q, scl_n_d;
  logic       sda_n_q, sda_n_d;
  logic       done_q, done_d;
  logic [7:0] low_u, high_u, hold_u, setup_u;
  assign low_u   = timing_q[`IBT_LOW_MSB:`IBT_LOW_LSB];
  assign high_u  = timing_q[`IBT_HIGH_MSB:`IBT_HIGH_LSB];
  assign hold_u  = {4'h0, timing_q[`IBT_HOLD_MSB:`IBT_HOLD_LSB]};
  assign setup_u = {4'h0, timing_q[`IBT_SETUP_MSB:`IBT_SETUP_LSB]};
  // Units since SCL fell, and the two end points of the low phase
  logic [8:0] elapsed, hs_end, low_end;
  assign elapsed = {1'b0, units_q} + 9'h001;
  assign hs_end  = {1'b0, hold_u} + {1'b0, setup_u} + 9'h001;
  assign low_end = {1'b0, low_u} + 9'h001;

  always_comb begin
    ph_d    = ph_q;
    units_d = units_q;
    scl_n_d = scl_n_q;
    sda_n_d = sda_n_q;
    done_d  = 1'b0;
    unique case (ph_q)
      ibt_pkg::IBT_IDLE: begin
        scl_n_d = 1'b1;
        sda_n_d = 1'b1;
        if (periph_en && xfer_active && tick_q) begin
          ph_d    = ibt_pkg::IBT_LOW_HOLD;
          scl_n_d = 1'b0;
          units_d = 8'h00;
          if (hold_u == 8'h00) begin
            sda_n_d = tx_mode ? tx_bit : 1'b1;
            ph_d    = ibt_pkg::IBT_LOW_SETUP;
          end
        end
      end
      ibt_pkg::IBT_LOW_HOLD: begin
        if (tick_q) begin
          units_d = units_q + 8'h01;
          if (elapsed >= {1'b0, hold_u}) begin
            sda_n_d = tx_mode ? tx_bit : 1'b1;
            ph_d    = ibt_pkg::IBT_LOW_SETUP;
          end
        end
      end
      ibt_pkg::IBT_LOW_SETUP: begin
        if (tick_q) begin
          units_d = units_q + 8'h01;
          if (elapsed >= hs_end) begin
            if (elapsed >= low_end) begin
              ph_d    = ibt_pkg::IBT_HIGH;
              scl_n_d = 1'b1;
              units_d = 8'h00;
            end else begin
              ph_d = ibt_pkg::IBT_LOW_REST;
            end
          end
        end
      end
      ibt_pkg::IBT_LOW_REST: begin
        // Low total is the larger of both ends
        if (tick_q) begin
          units_d = units_q + 8'h01;
          if (elapsed >= low_end) begin
            ph_d    = ibt_pkg::IBT_HIGH;
            scl_n_d = 1'b1;
            units_d = 8'h00;
          end
        end
      end
      ibt_pkg::IBT_HIGH: begin
        // Count only once the line really rose (stretching)
        if (tick_q && scl_in) begin
          if (units_q == high_u) begin
            done_d  = 1'b1;
            units_d = 8'h00;
            if (periph_en && xfer_active) begin
              ph_d    = ibt_pkg::IBT_LOW_HOLD;
              scl_n_d = 1'b0;
              if (hold_u == 8'h00) begin
                sda_n_d = tx_mode ? tx_bit : 1'b1;
                ph_d    = ibt_pkg::IBT_LOW_SETUP;
              end
            end else begin
              ph_d = ibt_pkg::IBT_IDLE;
            end
          end else begin
            units_d = units_q + 8'h01;
          end
        end
      end
    endcase
    if (!periph_en) begin
      ph_d    = ibt_pkg::IBT_IDLE;
      scl_n_d = 1'b1;
      sda_n_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ph_q    <= ibt_pkg::IBT_IDLE;
      units_q <= 8'h00;
      scl_n_q <= 1'b1;
      sda_n_q <= 1'b1;
      done_q  <= 1'b0;
      xfer_q  <= 1'b0;
    end else begin
      ph_q    <= ph_d;
      units_q <= units_d;
      scl_n_q <= scl_n_d;
      sda_n_q <= sda_n_d;
      done_q  <= done_d;
      xfer_q  <= xfer_active;
    end
  end

  assign scl_oe_n = scl_n_q;
  assign sda_oe_n = sda_n_q;
  assign bit_done = done_q;

  // Stuck-low detector, selected when bit 12 is 0
  ibt_timeout #(.LIMIT_W(12), .SCALE(`IBT_LONG_SCALE)) u_low (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enable  (clkto_en && !idle_sel),
    .active  (!scl_in),
    .restart (scl_in),
    .limit   (tocfg_q[`IBT_TOA_MSB:`IBT_TOA_LSB]),
    .expired (lowto)
  );

  // Bus idle detector, selected when bit 12 is 1
  ibt_timeout #(.LIMIT_W(12), .SCALE(`IBT_IDLE_SCALE)) u_idle (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enable  (clkto_en && idle_sel),
    .active  (scl_in && sda_in),
    .restart (!(scl_in && sda_in)),
    .limit   (tocfg_q[`IBT_TOA_MSB:`IBT_TOA_LSB]),
    .expired (idleto)
  );

  // Stretch detector: one unbroken low run this end did not drive
  ibt_timeout #(.LIMIT_W(12), .SCALE(`IBT_LONG_SCALE)) u_ext (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enable  (exto_en && xfer_active),
    .active  (ph_q == ibt_pkg::IBT_HIGH && !scl_in),
    .restart (xfer_active != xfer_q),
    .limit   (tocfg_q[`IBT_TOB_MSB:`IBT_TOB_LSB]),
    .expired (extto)
  );

  assign ev = {extto, idleto, lowto};
endmodule

// >>> ibt_bus.sv
/* Pull-up model of the I2C wires and peer devices.
   Assumes open-drain enables that are low while driving. */
`timescale 1ns/1ps
module ibt_bus (
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  input  wire logic peer_scl_low,
  input  wire logic peer_sda_low,
  output logic      scl_in,
  output logic      sda_in
);
  // Wired-AND lines, pulled high when released
  assign scl_in = scl_oe_n & !peer_scl_low;
  assign sda_in = sda_oe_n & !peer_sda_low;
endmodule

// >>> ibt_chk.sv
/* Port checker for the bit-timing block.
   Assumes one clock and a sync reset. */
`timescale 1ns/1ps
module ibt_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic xfer_active,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic bit_done,
  input wire logic timeout_err
);
  logic [11:0] low_q, low_d;
  logic [2:0]  idl_q, idl_d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Unbroken SCL low run and idle run
  always_comb begin
    low_d = scl_in ? 12'h000 : low_q + {11'h000, low_q != 12'hFFF};
    idl_d = !(scl_in && sda_in) ? 3'h0 : idl_q + {2'h0, idl_q != 3'h7};
  end
  // Helper registers
  always_ff @(posedge sys_clk) begin
    low_q <= rst ? 12'h000 : low_d;
    idl_q <= rst ? 3'h0 : idl_d;
  end
  AST_PREADY_WAIT:
    assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_PREADY_ONE:
    assert property (pready |=> !pready)
    else $error("pready too long");
  AST_SLVERR_QUAL:
    assert property (pslverr |-> pready)
    else $error("pslverr alone");
  AST_RESET_IDLE:
    assert property (disable iff (1'b0) rst |=> scl_oe_n && sda_oe_n
      && !timeout_err && !bit_done)
    else $error("reset state");
  AST_ERR_PULSE:
    assert property (timeout_err |=> !timeout_err)
    else $error("error not a pulse");
  AST_ERR_CAUSE:
    assert property (timeout_err |-> low_q >= 12'h7FF || idl_q >= 3'h3)
    else $error("error too early");
  AST_SCL_XFER:
    assert property ($fell(scl_oe_n) |-> $past(xfer_active))
    else $error("SCL driven idle");
  AST_SDA_IN_LOW:
    assert property ($changed(sda_oe_n) && $past(xfer_active) |-> !scl_oe_n)
    else $error("SDA moved with SCL high");
  AST_DONE_HIGH:
    assert property (bit_done |-> $past(scl_in) && $past(scl_oe_n, 2))
    else $error("bit end without high");
  cover property (timeout_err);
  cover property (bit_done);
  cover property (pready && pslverr);
endmodule
bind ibt_core ibt_chk i_chk (.sys_clk, .rst, .psel, .penable, .pready,
  .pslverr, .scl_in, .sda_in, .xfer_active, .scl_oe_n, .sda_oe_n,
  .bit_done, .timeout_err);

// >>> testbench.sv
/* Self-checking bench for the bit-timing block.
   Assumes the checker is bound to the core. */
`timescale 1ns/1ps
module testbench;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        scl_in, sda_in, xfer_active, tx_bit, tx_mode, irq;
  logic        scl_oe_n, sda_oe_n, bit_done, timeout_err, peer_scl_low;
  int          fails = 0, tests_run = 0, n_err = 0, n_done = 0;
  ibt_core i_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .scl_in, .sda_in, .xfer_active,
    .tx_bit, .tx_mode, .scl_oe_n, .sda_oe_n, .bit_done, .timeout_err, .irq);
  ibt_bus i_bus (.scl_oe_n, .sda_oe_n, .peer_scl_low,
    .peer_sda_low(1'b0), .scl_in, .sda_in);
  // Kernel clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Output pulse tallies
  always @(posedge sys_clk) begin
    if (timeout_err === 1'b1) n_err++;
    if (bit_done === 1'b1) n_done++;
  end
  task automatic final_report;
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    tests_run++;
    if (g < lo || g > hi) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    e = pslverr;
    if (n == 20) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x,
                     input logic xe);
    logic e;
    apb(1'b0, a, 32'h0, e);
    if (!xe) chk(rv, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  // Reset values, field masks, refused writes
  task automatic t_regs;
    rdc(12'h010, 32'h0, 1'b0);
    rdc(12'h014, 32'h0, 1'b0);
    rdc(12'h030, 32'h0, 1'b1);
    wr(12'h010, 32'hFFFFFFFF);
    rdc(12'h010, 32'hF0FFFFFF, 1'b0);
    wr(12'h014, 32'h7FFF7FFF);
    wr(12'h014, 32'hFFFFFFFF);
    rdc(12'h014, 32'h8FFF9FFF, 1'b0);
    wr(12'h014, 32'h7FFF7FFF);
    wr(12'h014, 32'h0);
    wr(12'h018, 32'h1);
    wr(12'h010, 32'h0);
    rdc(12'h010, 32'hF0FFFFFF, 1'b0);
    wr(12'h018, 32'h0);
  endtask
  // One sent bit, peer stretches the low phase
  task automatic t_bit(input logic [31:0] w, input int elo);
    int lo, dl, hi, d0;
    wr(12'h010, w);
    wr(12'h018, 32'h1);
    d0 = n_done;
    xfer_active <= 1'b1;
    lo = 0;
    while (scl_oe_n !== 1'b0 && lo < 99) begin
      @(posedge sys_clk);
      lo++;
    end
    peer_scl_low <= 1'b1;
    lo = 0;
    dl = 0;
    while (scl_oe_n === 1'b0 && lo < 99) begin
      if (sda_oe_n === 1'b1) dl++;
      @(posedge sys_clk);
      lo++;
    end
    repeat (20) @(posedge sys_clk);
    peer_scl_low <= 1'b0;
    hi = 0;
    @(posedge sys_clk);
    while (scl_oe_n !== 1'b0 && hi < 99) begin
      @(posedge sys_clk);
      hi++;
    end
    xfer_active <= 1'b0;
    wr(12'h018, 32'h0);
    chk_rng(lo, elo, elo + 1);
    chk_rng(dl, 2, 3);
    chk_rng(hi, 5, 6);
    chk_rng(n_done - d0, 1, 1);
  endtask
  // SCL stuck low, a short run first
  task automatic t_low;
    int e0;
    wr(12'h020, 32'h7);
    wr(12'h014, 32'h0);
    wr(12'h014, 32'h8000);
    e0 = n_err;
    peer_scl_low <= 1'b1;
    repeat (2000) @(posedge sys_clk);
    peer_scl_low <= 1'b0;
    repeat (5) @(posedge sys_clk);
    peer_scl_low <= 1'b1;
    repeat (2040) @(posedge sys_clk);
    chk_rng(n_err - e0, 0, 0);
    repeat (20) @(posedge sys_clk);
    chk_rng(n_err - e0, 1, 1);
    peer_scl_low <= 1'b0;
    rdc(12'h01C, 32'h1, 1'b0);
    chk({31'h0, irq}, 32'h1);
    wr(12'h014, 32'h0);
    wr(12'h024, 32'h1);
    rdc(12'h01C, 32'h0, 1'b0);
    chk({31'h0, irq}, 32'h0);
  endtask
  // Idle bus, masked then unmasked
  task automatic t_idle;
    int e0;
    wr(12'h020, 32'h0);
    wr(12'h014, 32'h1002);
    wr(12'h014, 32'h9002);
    e0 = n_err;
    repeat (10) @(posedge sys_clk);
    chk_rng(n_err - e0, 0, 0);
    repeat (5) @(posedge sys_clk);
    chk_rng(n_err - e0, 1, 1);
    chk({31'h0, irq}, 32'h0);
    wr(12'h020, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(12'h014, 32'h1002);
    wr(12'h024, 32'h2);
    rdc(12'h01C, 32'h0, 1'b0);
  endtask
  // Stretch run, measured per transfer
  task automatic t_stretch;
    int len[3] = '{1100, 1100, 2080};
    wr(12'h020, 32'h4);
    wr(12'h014, 32'h0);
    wr(12'h014, 32'h80000000);
    wr(12'h018, 32'h1);
    foreach (len[i]) begin
      xfer_active <= 1'b1;
      peer_scl_low <= 1'b1;
      repeat (len[i]) @(posedge sys_clk);
      peer_scl_low <= 1'b0;
      xfer_active <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rdc(12'h01C, i == 2 ? 32'h4 : 32'h0, 1'b0);
    end
    chk({31'h0, irq}, 32'h1);
    wr(12'h018, 32'h0);
  endtask
  // Reset, then the scenarios
  initial begin
    {rst, psel, penable, pwrite, xfer_active} = 5'h10;
    {tx_bit, tx_mode, peer_scl_low} = 3'h2;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_bit(32'h10A10201, 24);
    t_bit(32'h10110205, 12);
    t_low();
    t_idle();
    t_stretch();
    final_report();
  end
  // Hang guard, about 30000 cycles
  initial begin
    #1500000;
    fails++;
    final_report();
  end
endmodule
